// File: ldcw_chk.sv
`timescale 1ns/1ps
module ldcw_chk (
	input wire core_clk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire interrupt_line_n,
	input wire rc_calibration_done,
	input wire radio_rx_r,
	input wire radio_tx_r,
	input wire radio_sleep_r,
	input wire wake_event_r,
	input wire rx_timeout_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside answer");
	chk_wake_pulse: assert property (wake_event_r |=> !wake_event_r)
		else $error("wake event longer than one cycle");
	chk_wake_slot: assert property (wake_event_r |-> ##[0:2] (radio_rx_r || radio_tx_r))
		else $error("wake event without slot");
	chk_tmo_pulse: assert property (rx_timeout_r |=> !rx_timeout_r)
		else $error("timeout longer than one cycle");
	chk_tmo_in_rx: assert property (rx_timeout_r |-> radio_rx_r || $past(radio_rx_r))
		else $error("timeout outside receive");
	chk_state_excl: assert property ($onehot0({radio_rx_r, radio_tx_r, radio_sleep_r}))
		else $error("radio states overlap");
	// Register writes break the window: a sleep command may legally follow
	chk_cal_gate: assert property ((!rc_calibration_done && !reg_wr)[*8] |=> !$rose(radio_sleep_r))
		else $error("sleep before calibration done");
	chk_irq_hold: assert property ((!interrupt_line_n && !reg_wr)[*8] |=> !$rose(radio_sleep_r))
		else $error("sleep with interrupt pending");
	cov_wake: cover property (wake_event_r ##[1:3] radio_rx_r);
	cov_tx: cover property ($rose(radio_tx_r));
	cov_tmo: cover property (rx_timeout_r);
endmodule
bind ldcw_wakeup ldcw_chk chk_u (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_rdata,
	.interrupt_line_n, .rc_calibration_done, .radio_rx_r, .radio_tx_r, .radio_sleep_r,
	.wake_event_r, .rx_timeout_r);

// File: ldcw_map.vh
`ifndef LDCW_MAP_VH
`define LDCW_MAP_VH
`define LDCW_ADDR_W 4
`define LDCW_A_CTRL 4'h0
`define LDCW_A_WAKE_PRESC 4'h1
`define LDCW_A_WAKE_CNT 4'h2
`define LDCW_A_RLD_PRESC 4'h3
`define LDCW_A_RLD_CNT 4'h4
`define LDCW_A_RX_TMO 4'h5
`define LDCW_A_SNIFF 4'h6
`define LDCW_A_CMD 4'h7
`define LDCW_A_STATUS 4'h8
`define LDCW_A_TIMER 4'h9
`define LDCW_B_DC_EN 0
`define LDCW_B_TX_ROLE 1
`define LDCW_B_SYNC_RLD 2
`define LDCW_B_SNIFF_EN 3
`define LDCW_B_AUTO_ACK 4
`define LDCW_B_EXT_CLK 5
`define LDCW_F_SCALE_LO 6
`define LDCW_F_CHF_LO 8
`define LDCW_C_RX 8'h01
`define LDCW_C_TX 8'h02
`define LDCW_C_RELOAD 8'h03
`define LDCW_C_SLEEP 8'h04
`define LDCW_C_READY 8'h05
`define LDCW_SNIFF_BASE 24
`endif

// File: ldcw_peer.sv
`timescale 1ns/1ps
module ldcw_peer (
	input wire core_clk,
	input wire rst_n,
	input wire radio_tx_r,
	output logic rc_oscillator,
	output logic tx_done
);
	logic tx_q;
	logic [3:0] cnt;
	initial rc_oscillator = 1'b0;
	// Edges fall on core falling edges, midway between rising edges, in fixed phase
	always #40 rc_oscillator = ~rc_oscillator;
	// Done held several cycles so the level sampler sees it
	always @(posedge core_clk) begin
		tx_q <= radio_tx_r;
		if (!rst_n)
			cnt <= 4'h0;
		else if (radio_tx_r && !tx_q)
			cnt <= 4'h1;
		else if (cnt != 4'h0)
			cnt <= cnt + 4'h1;
	end
	assign tx_done = cnt >= 4'h7;
endmodule

// File: ldcw_wakeup.v
`timescale 1ns/1ps
`include "ldcw_map.vh"
module ldcw_wakeup #(
	parameter CW = 8
) (
	input wire core_clk,
	input wire rst_n,
	input wire [`LDCW_ADDR_W-1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire rc_oscillator,
	input wire ext_wake_clk,
	input wire interrupt_line_n,
	input wire rc_calibration_done,
	input wire tx_fifo_nonempty,
	input wire sync_detect,
	input wire pkt_received,
	input wire carrier_valid,
	input wire tx_done,
	input wire ack_done,
	output reg radio_rx_r,
	output reg radio_tx_r,
	output reg radio_sleep_r,
	output reg wake_event_r,
	output reg rx_timeout_r
);
	localparam S_READY = 3'd0;
	localparam S_SLEEP = 3'd1;
	localparam S_RX = 3'd2;
	localparam S_TX = 3'd3;
	localparam S_WAIT_SLEEP = 3'd4;
	localparam S_ACK_TX = 3'd5;
	localparam S_ACK_RX = 3'd6;

	reg [15:0] ctrl_r;
	reg [7:0] wake_presc_r;
	reg [7:0] wake_cnt_r;
	reg [7:0] rld_presc_r;
	reg [7:0] rld_cnt_r;
	reg [7:0] sniff_lim_r;
	reg [15:0] rx_tmo_r;
	reg [2:0] state_r;
	reg first_tx_r;
	reg stop_req_r;
	reg [2:0] rc_sync_r;
	reg [2:0] ext_sync_r;
	reg [1:0] irq_sync_r;
	reg [1:0] cal_sync_r;
	reg [1:0] fifo_sync_r;
	reg [1:0] cs_sync_r;
	reg [1:0] sw_sync_r;
	reg [1:0] pkt_sync_r;
	reg [1:0] txd_sync_r;
	reg [1:0] ackd_sync_r;
	reg [2:0] scale_div_r;
	reg [7:0] presc_cnt_r;
	reg [7:0] wake_left_r;
	reg [15:0] rx_left_r;
	reg rx_armed_r;
	reg sniff_on_r;
	reg [12:0] sniff_div_r;
	reg [7:0] sniff_left_r;
	reg load_wake;
	reg expire;

	wire dc_en = ctrl_r[`LDCW_B_DC_EN];
	wire tx_role = ctrl_r[`LDCW_B_TX_ROLE];
	wire [1:0] scale = ctrl_r[`LDCW_F_SCALE_LO+1:`LDCW_F_SCALE_LO];
	wire [2:0] chf_e = ctrl_r[`LDCW_F_CHF_LO+2:`LDCW_F_CHF_LO];
	wire cmd_wr = reg_wr && reg_addr == `LDCW_A_CMD;
	wire [7:0] cmd = reg_wdata[7:0];
	wire irq_idle = irq_sync_r[1];
	wire cal_ok = cal_sync_r[1];
	wire fifo_ne = fifo_sync_r[1];
	wire cs_ok = cs_sync_r[1];
	wire sync_hit = sw_sync_r[1];
	wire pkt_hit = pkt_sync_r[1];
	wire tx_fin = txd_sync_r[1];
	wire ack_fin = ackd_sync_r[1];
	// Wake source edge, taken only after both sync stages
	wire src_lvl = ctrl_r[`LDCW_B_EXT_CLK] ? ext_sync_r[1] : rc_sync_r[1];
	wire src_prev = ctrl_r[`LDCW_B_EXT_CLK] ? ext_sync_r[2] : rc_sync_r[2];
	wire src_rise = src_lvl && !src_prev;
	wire [2:0] scale_mask = (3'd1 << scale) - 3'd1;
	wire wake_tick = src_rise && ((scale_div_r & scale_mask) == 3'd0);
	wire [12:0] sniff_period = (13'd`LDCW_SNIFF_BASE << chf_e) - 13'd1;
	wire rx_slot = state_r == S_RX || state_r == S_ACK_RX;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			rc_sync_r <= 3'h0;
			ext_sync_r <= 3'h0;
			irq_sync_r <= 2'h3;
			cal_sync_r <= 2'h0;
			fifo_sync_r <= 2'h0;
			cs_sync_r <= 2'h0;
			sw_sync_r <= 2'h0;
			pkt_sync_r <= 2'h0;
			txd_sync_r <= 2'h0;
			ackd_sync_r <= 2'h0;
		end else begin
			rc_sync_r <= {rc_sync_r[1:0], rc_oscillator};
			ext_sync_r <= {ext_sync_r[1:0], ext_wake_clk};
			irq_sync_r <= {irq_sync_r[0], interrupt_line_n};
			cal_sync_r <= {cal_sync_r[0], rc_calibration_done};
			fifo_sync_r <= {fifo_sync_r[0], tx_fifo_nonempty};
			cs_sync_r <= {cs_sync_r[0], carrier_valid};
			sw_sync_r <= {sw_sync_r[0], sync_detect};
			pkt_sync_r <= {pkt_sync_r[0], pkt_received};
			txd_sync_r <= {txd_sync_r[0], tx_done};
			ackd_sync_r <= {ackd_sync_r[0], ack_done};
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_r <= 16'h0000;
			wake_presc_r <= 8'hff;
			wake_cnt_r <= 8'hff;
			rld_presc_r <= 8'hff;
			rld_cnt_r <= 8'hff;
			rx_tmo_r <= 16'hffff;
			sniff_lim_r <= 8'h10;
		end else if (reg_wr) begin
			case (reg_addr)
			`LDCW_A_CTRL: ctrl_r <= reg_wdata;
			`LDCW_A_WAKE_PRESC: wake_presc_r <= reg_wdata[7:0];
			`LDCW_A_WAKE_CNT: wake_cnt_r <= reg_wdata[7:0];
			`LDCW_A_RLD_PRESC: rld_presc_r <= reg_wdata[7:0];
			`LDCW_A_RLD_CNT: rld_cnt_r <= reg_wdata[7:0];
			`LDCW_A_RX_TMO: rx_tmo_r <= reg_wdata;
			`LDCW_A_SNIFF: sniff_lim_r <= reg_wdata[7:0];
			default: ;
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
			`LDCW_A_CTRL: reg_rdata <= ctrl_r;
			`LDCW_A_WAKE_PRESC: reg_rdata <= {8'h00, wake_presc_r};
			`LDCW_A_WAKE_CNT: reg_rdata <= {8'h00, wake_cnt_r};
			`LDCW_A_RLD_PRESC: reg_rdata <= {8'h00, rld_presc_r};
			`LDCW_A_RLD_CNT: reg_rdata <= {8'h00, rld_cnt_r};
			`LDCW_A_RX_TMO: reg_rdata <= rx_tmo_r;
			`LDCW_A_SNIFF: reg_rdata <= {8'h00, sniff_lim_r};
			`LDCW_A_STATUS: reg_rdata <= {11'h000, stop_req_r, first_tx_r, state_r};
			`LDCW_A_TIMER: reg_rdata <= {presc_cnt_r, wake_left_r};
			default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// Whether to load the reload values into the wake timer this cycle
	always @* begin
		load_wake = 1'b0;
		if (cmd_wr && cmd == `LDCW_C_RELOAD) begin
			load_wake = 1'b1;
		end
		if (state_r == S_RX && !tx_role && ctrl_r[`LDCW_B_SYNC_RLD] && sync_hit) begin
			load_wake = 1'b1;
		end
		if (state_r == S_TX && first_tx_r) begin
			load_wake = 1'b1;
		end
	end

	always @* begin
		expire = wake_tick && presc_cnt_r == 8'h00 && wake_left_r == 8'h00;
	end

	// Wake timer: period (presc+1)*(cnt+1) wake ticks, keeps counting when disabled
	always @(posedge core_clk) begin
		if (!rst_n) begin
			scale_div_r <= 3'h0;
			presc_cnt_r <= 8'h00;
			wake_left_r <= 8'h00;
		end else begin
			if (src_rise) begin
				scale_div_r <= scale_div_r + 3'd1;
			end
			if (load_wake) begin
				presc_cnt_r <= rld_presc_r;
				wake_left_r <= rld_cnt_r;
			end else if (wake_tick) begin
				if (presc_cnt_r != 8'h00) begin
					presc_cnt_r <= presc_cnt_r - 8'd1;
				end else if (wake_left_r != 8'h00) begin
					presc_cnt_r <= wake_presc_r;
					wake_left_r <= wake_left_r - 8'd1;
				end else begin
					presc_cnt_r <= wake_presc_r;
					wake_left_r <= wake_cnt_r;
				end
			end
		end
	end

	// Slot sequencer
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= S_READY;
			first_tx_r <= 1'b0;
			stop_req_r <= 1'b0;
			wake_event_r <= 1'b0;
			rx_timeout_r <= 1'b0;
			rx_left_r <= 16'h0000;
			rx_armed_r <= 1'b0;
			sniff_on_r <= 1'b0;
			sniff_div_r <= 13'h0000;
			sniff_left_r <= 8'h00;
		end else begin
			wake_event_r <= 1'b0;
			rx_timeout_r <= 1'b0;
			if (!dc_en && state_r != S_READY && state_r != S_SLEEP) begin
				stop_req_r <= 1'b1;
			end
			if (rx_slot && rx_armed_r && rx_left_r != 16'h0000) begin
				rx_left_r <= rx_left_r - 16'd1;
			end
			if (rx_slot && sniff_on_r) begin
				if (sniff_div_r == 13'h0000) begin
					sniff_div_r <= sniff_period;
					if (sniff_left_r != 8'h00) begin
						sniff_left_r <= sniff_left_r - 8'd1;
					end
				end else begin
					sniff_div_r <= sniff_div_r - 13'd1;
				end
			end
			case (state_r)
			S_READY: begin
				stop_req_r <= 1'b0;
				if (cmd_wr && dc_en && cmd == `LDCW_C_RX) begin
					state_r <= S_RX;
					rx_left_r <= rx_tmo_r;
					rx_armed_r <= !ctrl_r[`LDCW_B_SNIFF_EN];
					sniff_on_r <= ctrl_r[`LDCW_B_SNIFF_EN];
					sniff_div_r <= sniff_period;
					sniff_left_r <= sniff_lim_r;
				end else if (cmd_wr && dc_en && cmd == `LDCW_C_TX) begin
					state_r <= S_TX;
					first_tx_r <= 1'b1;
				end
			end
			S_SLEEP: begin
				if (cmd_wr && cmd == `LDCW_C_READY) begin
					state_r <= S_READY;
				end else if (tx_role && !dc_en && fifo_ne) begin
					// Stopped in sleep: queued data still leaves once
					// Empty queue keeps sleeping until data or ready command
					state_r <= S_TX;
				end else if (expire && dc_en) begin
					if (tx_role) begin
						if (fifo_ne) begin
							state_r <= S_TX;
							wake_event_r <= 1'b1;
						end
					end else begin
						state_r <= S_RX;
						wake_event_r <= 1'b1;
						rx_left_r <= rx_tmo_r;
						rx_armed_r <= !ctrl_r[`LDCW_B_SNIFF_EN];
						sniff_on_r <= ctrl_r[`LDCW_B_SNIFF_EN];
						sniff_div_r <= sniff_period;
						sniff_left_r <= sniff_lim_r;
					end
				end
			end
			S_RX, S_ACK_RX: begin
				if (sniff_on_r && sniff_left_r == 8'h00) begin
					sniff_on_r <= 1'b0;
					if (cs_ok) begin
						rx_armed_r <= 1'b1;
					end else begin
						state_r <= S_WAIT_SLEEP;
						rx_timeout_r <= 1'b1;
					end
				end else if (pkt_hit) begin
					rx_armed_r <= 1'b0;
					if (state_r == S_RX && ctrl_r[`LDCW_B_AUTO_ACK]) begin
						state_r <= S_ACK_TX;
					end else begin
						state_r <= S_WAIT_SLEEP;
					end
				end else if (rx_armed_r && rx_left_r == 16'h0000) begin
					rx_armed_r <= 1'b0;
					rx_timeout_r <= 1'b1;
					state_r <= S_WAIT_SLEEP;
				end
			end
			S_TX: begin
				first_tx_r <= 1'b0;
				if (tx_fin && !first_tx_r) begin
					if (ctrl_r[`LDCW_B_AUTO_ACK]) begin
						state_r <= S_ACK_RX;
						rx_left_r <= rx_tmo_r;
						rx_armed_r <= 1'b1;
						sniff_on_r <= 1'b0;
					end else begin
						state_r <= S_WAIT_SLEEP;
					end
				end
			end
			S_ACK_TX: begin
				if (ack_fin) begin
					state_r <= S_WAIT_SLEEP;
				end
			end
			S_WAIT_SLEEP: begin
				// Calibration gate avoids automatic sleep on an untrimmed oscillator
				if (stop_req_r || !dc_en) begin
					state_r <= S_READY;
				end else if (cmd_wr && cmd == `LDCW_C_SLEEP) begin
					state_r <= S_SLEEP;
				end else if (irq_idle && cal_ok) begin
					state_r <= S_SLEEP;
				end
			end
			default: state_r <= S_READY;
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			radio_rx_r <= 1'b0;
			radio_tx_r <= 1'b0;
			radio_sleep_r <= 1'b0;
		end else begin
			radio_rx_r <= rx_slot;
			radio_tx_r <= state_r == S_TX || state_r == S_ACK_TX;
			radio_sleep_r <= state_r == S_SLEEP;
		end
	end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic interrupt_line_n = 1, rc_calibration_done = 1, tx_fifo_nonempty = 0;
	logic carrier_valid = 0;
	logic sync_detect = 0, pkt_received = 0, ack_done = 0;
	logic rc_oscillator, tx_done, radio_rx_r, radio_tx_r, radio_sleep_r, wake_event_r;
	logic rx_timeout_r;
	int err_total = 0, n_checks = 0;
	always #5 core_clk = ~core_clk;
	ldcw_wakeup dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rc_oscillator, .ext_wake_clk(1'b0), .interrupt_line_n,
		.rc_calibration_done, .tx_fifo_nonempty, .sync_detect, .pkt_received,
		.carrier_valid, .tx_done, .ack_done, .radio_rx_r, .radio_tx_r,
		.radio_sleep_r, .wake_event_r, .rx_timeout_r);
	ldcw_peer peer_u (.core_clk, .rst_n, .radio_tx_r, .rc_oscillator, .tx_done);
	task automatic fail(input string m);
		err_total++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		n_checks++;
		if ((reg_rdata & m) !== e)
			fail("read value wrong");
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return radio_rx_r;
			1: return radio_tx_r;
			2: return radio_sleep_r;
			3: return wake_event_r;
			4: return rx_timeout_r;
			default: return ~radio_tx_r;
		endcase
	endfunction
	// Wait up to n cycles; stops early once seen
	task automatic see(input int s, input int n, input bit e);
		bit hit;
		hit = 0;
		while (n > 0 && !hit) begin
			@(posedge core_clk);
			#1;
			if (sig(s) === 1'b1)
				hit = 1;
			n--;
		end
		n_checks++;
		if (hit != e)
			fail("output event wrong");
	endtask
	task automatic t_regs;
		rd(4'h1, 16'hffff, 16'h00ff);
		rd(4'h4, 16'hffff, 16'h00ff);
		rd(4'h5, 16'hffff, 16'hffff);
		rd(4'h8, 16'h0007, 16'h0000);
		rd(4'hf, 16'hffff, 16'h0000);
		wr(4'h1, 16'h0001);
		rd(4'h1, 16'hffff, 16'h0001);
	endtask
	task automatic t_rx;
		wr(4'h2, 16'h0003);
		wr(4'h5, 16'h0014);
		rc_calibration_done <= 1'b0;
		wr(4'h0, 16'h0001);
		wr(4'h7, 16'h0001);
		see(0, 5, 1);
		see(4, 40, 1);
		see(2, 15, 0);
		@(posedge core_clk);
		rc_calibration_done <= 1'b1;
		see(2, 10, 1);
		wr(4'h3, 16'h0000);
		wr(4'h4, 16'h0001);
		wr(4'h7, 16'h0003);
		see(3, 30, 1);
		see(0, 5, 1);
		see(4, 40, 1);
		see(2, 10, 1);
		see(3, 100, 1);
	endtask
	task automatic t_irq;
		see(0, 5, 1);
		@(posedge core_clk);
		interrupt_line_n <= 1'b0;
		see(4, 40, 1);
		see(2, 30, 0);
		wr(4'h7, 16'h0004);
		see(2, 5, 1);
		@(posedge core_clk);
		interrupt_line_n <= 1'b1;
	endtask
	task automatic t_stop;
		wr(4'h0, 16'h0000);
		see(3, 200, 0);
		wr(4'h7, 16'h0005);
		rd(4'h8, 16'h0007, 16'h0000);
	endtask
	task automatic t_tx;
		wr(4'h0, 16'h0003);
		wr(4'h7, 16'h0002);
		see(1, 5, 1);
		see(2, 30, 1);
		see(1, 150, 0);
		@(posedge core_clk);
		tx_fifo_nonempty <= 1'b1;
		see(1, 100, 1);
		see(2, 30, 1);
		wr(4'h0, 16'h0002);
		see(1, 100, 1);
		see(5, 30, 1);
		rd(4'h8, 16'h0007, 16'h0000);
		@(posedge core_clk);
		tx_fifo_nonempty <= 1'b0;
	endtask
	// Tick 24 cycles at exponent 0, limit 2 ticks
	task automatic t_sniff;
		wr(4'h5, 16'hffff);
		wr(4'h6, 16'h0002);
		wr(4'h0, 16'h0009);
		wr(4'h7, 16'h0001);
		see(4, 40, 0);
		see(4, 30, 1);
		see(3, 100, 1);
		@(posedge core_clk);
		carrier_valid <= 1'b1;
		see(4, 150, 0);
	endtask
	// Still in the carrier-held receive slot: sync reload, ack answer, then sender side
	task automatic t_ack;
		wr(4'h0, 16'h0015);
		@(posedge core_clk);
		sync_detect <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(4'h9, 16'hffff, 16'h0001);
		sync_detect <= 1'b0;
		pkt_received <= 1'b1;
		see(1, 10, 1);
		wr(4'h0, 16'h0013);
		tx_fifo_nonempty <= 1'b1;
		pkt_received <= 1'b0;
		ack_done <= 1'b1;
		see(2, 10, 1);
		ack_done <= 1'b0;
		see(1, 100, 1);
		see(0, 40, 1);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs;
		t_rx;
		t_irq;
		t_stop;
		t_tx;
		t_sniff;
		t_ack;
		end_sim;
	end
	initial begin
		#100000;
		fail("watchdog expired");
		end_sim;
	end
endmodule
